// ### core/coproc_pkg.sv
// Constants and types for the coprocessor channel port.
// Assumes one 125 MHz clock and an Avalon-MM register master.
package coproc_pkg;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] STAT_OFS = 4'h1;
  localparam logic [ADDR_W-1:0] OPA_OFS = 4'h2;
  localparam logic [ADDR_W-1:0] OPB_OFS = 4'h3;
  localparam logic [ADDR_W-1:0] CMD_OFS = 4'h4;
  localparam logic [ADDR_W-1:0] RES_OFS = 4'h5;
  localparam logic [ADDR_W-1:0] OLD_OFS = 4'h6;
  localparam logic [ADDR_W-1:0] TRAP_OFS = 4'h7;
  // Control register bits
  localparam int CTRL_PRESENT = 0;
  localparam int CTRL_SUPER = 1;
  localparam int CTRL_IRQ_MASK = 2;
  localparam int CTRL_ALL_MASK = 3;
  localparam logic [3:0] CTRL_RESET = 4'h2;
  // Command register bits
  localparam int CMD_LOAD = 0;
  localparam int CMD_TC = 1;
  localparam int CMD_SA = 2;
  localparam int CMD_OPT_LO = 4;
  localparam int CMD_GO = 8;
  localparam int CMD_TRAPTAKE = 9;
  // Status bits
  localparam int ST_ACTIVE = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_NOTPRES = 2;
  localparam int ST_CPEXC = 3;
  localparam logic [31:0] UNMAPPED = 32'h0000_0000;
  typedef enum logic [1:0] {TRAP_NONE, TRAP_NOTPRES, TRAP_CPEXC} trap_e;
  typedef enum {S_IDLE, S_STORE, S_LOAD} xfer_e;
endpackage

// ### core/status_word.sv
// Processor status bits: active flag, old copy, masks.
// Assumes one clock; updates come as one-cycle pulses.
`timescale 1ns/100ps
module status_word
  import coproc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Update requests
  input wire logic set_active,
  input wire logic clr_active,
  input wire logic trap_taken,
  input wire logic mask_wr,
  input wire logic supervisor,
  input wire logic irq_mask_in,
  input wire logic all_mask_in,
  // State
  output logic operation_active_flag,
  output logic old_active_reg,
  output logic irq_mask_bit,
  output logic all_trap_mask_bit
);
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      operation_active_flag <= 1'b0;
    end else if (set_active) begin
      operation_active_flag <= 1'b1;
    end else if (clr_active) begin
      operation_active_flag <= 1'b0;
    end
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      old_active_reg <= 1'b0;
    end else if (trap_taken) begin
      old_active_reg <= operation_active_flag;
    end
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_mask_bit <= 1'b0;
      all_trap_mask_bit <= 1'b0;
    end else if (mask_wr && supervisor) begin
      irq_mask_bit <= irq_mask_in;
      all_trap_mask_bit <= all_mask_in;
    end
  end
  property p_mask_guard;
    @(posedge sys_clk) disable iff (!reset_n)
      (mask_wr && !supervisor) |=> $stable(irq_mask_bit) && $stable(all_trap_mask_bit);
  endproperty
  a_mask_guard: assert property (p_mask_guard)
    else $error("mask changed from user mode");
  property p_set;
    @(posedge sys_clk) disable iff (!reset_n)
      set_active |=> operation_active_flag;
  endproperty
  a_set: assert property (p_set)
    else $error("active flag not set");
  property p_old;
    @(posedge sys_clk) disable iff (!reset_n)
      trap_taken |=> old_active_reg == $past(operation_active_flag);
  endproperty
  a_old: assert property (p_old)
    else $error("old copy wrong");
endmodule

// ### core/xfer_latch.sv
// Holds one outgoing request stable until acknowledged.
// Assumes load pulse only when idle.
`timescale 1ns/100ps
module xfer_latch #(
  parameter int W = 70
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Capture
  input wire logic load,
  input wire logic [W-1:0] din,
  // Held value
  output logic [W-1:0] dout
);
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dout <= '0;
    end else if (load) begin
      dout <= din;
    end
  end
endmodule

// ### core/coproc_channel_port.sv
// Coprocessor channel port: Avalon-MM registers, channel request side.
// Assumes channel inputs synchronous to sys_clk; coprocessor on far side.
// How it works
// - active flag one means operation started, results not yet read.
// - store with mark bit sets flag, load clears, zero leaves it.
// - trap entry copies active flag into old status copy.
// - present bit clear makes load or store trap, no transfer.
// - interrupt masks writable only in supervisor mode.
// - store drives 64 bits on address and data buses together.
// - load takes 32 bits from data bus only.
// - select line high for every coprocessor request.
// - qualifier with write starts operation; with read it has no effect, errors still trap.
// - store completes on accept; data-ready ignored.
// - store waits while accept inactive, request stays pending.
// - load completes on data-ready.
// - three type lines driven during transfers.
// - stores use write protocol, loads read protocol.
// - load puts operand B on address bus.
// - data error in transfer gives coprocessor exception trap.
// - control bit drives qualifier line.
`timescale 1ns/100ps
module coproc_channel_port
  import coproc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Channel request
  output logic chan_req,
  output logic chan_rw,
  output logic coproc_select_line,
  output logic transfer_qualifier_line,
  output logic [2:0] transfer_type_lines,
  output logic [31:0] chan_addr,
  output logic [31:0] chan_data_out,
  output logic chan_data_oe,
  // Channel response
  input wire logic [31:0] chan_data_in,
  input wire logic coproc_accept_line,
  input wire logic data_ready_input,
  input wire logic data_error_input,
  // Status outputs
  output logic operation_active_out,
  output logic trap_pending
);
  localparam int HW = 70;
  localparam int OPA_MSB = HW - 1;
  localparam int OPB_MSB = OPA_MSB - 32;
  logic [3:0] ctrl_reg;
  logic [31:0] opa_reg;
  logic [31:0] opb_reg;
  logic [31:0] result_reg;
  trap_e trap_reg;
  xfer_e state_reg;
  logic ack_reg;
  logic set_pulse;
  logic clr_pulse;
  logic trap_pulse;
  logic mask_pulse;
  logic start;
  logic go_store;
  logic go_load;
  logic done;
  logic [HW-1:0] hold_in;
  logic [HW-1:0] hold;
  logic active_flag;
  logic old_active;
  logic irq_mask;
  logic all_mask;
  logic err_seen;
  logic wr_acc;
  logic rd_acc;

  // Write lands on the edge that sees waitrequest low
  assign wr_acc = avs_write && ack_reg;
  assign rd_acc = avs_read && !ack_reg;
  assign start = wr_acc && avs_address == CMD_OFS && avs_writedata[CMD_GO] && state_reg == S_IDLE;
  assign go_store = start && ctrl_reg[CTRL_PRESENT] && !avs_writedata[CMD_LOAD];
  assign go_load = start && ctrl_reg[CTRL_PRESENT] && avs_writedata[CMD_LOAD];
  assign done = (state_reg == S_STORE && coproc_accept_line) ||
                (state_reg == S_LOAD && data_ready_input);
  assign set_pulse = done && state_reg == S_STORE && hold[CMD_SA];
  assign clr_pulse = done && state_reg == S_LOAD && hold[CMD_SA];
  assign err_seen = done && data_error_input;
  assign trap_pulse = wr_acc && avs_address == CMD_OFS && avs_writedata[CMD_TRAPTAKE];
  assign mask_pulse = wr_acc && avs_address == CTRL_OFS;
  assign hold_in = {opa_reg[31:0], opb_reg[31:0], avs_writedata[CMD_OPT_LO +: 3],
                    avs_writedata[CMD_SA], avs_writedata[CMD_TC], avs_writedata[CMD_LOAD]};

  xfer_latch #(
    .W(HW)
  ) u_hold (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .load(go_store || go_load),
    .din(hold_in),
    .dout(hold)
  );

  status_word u_status (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .set_active(set_pulse),
    .clr_active(clr_pulse),
    .trap_taken(trap_pulse),
    .mask_wr(mask_pulse),
    .supervisor(ctrl_reg[CTRL_SUPER]),
    .irq_mask_in(avs_writedata[CTRL_IRQ_MASK]),
    .all_mask_in(avs_writedata[CTRL_ALL_MASK]),
    .operation_active_flag(active_flag),
    .old_active_reg(old_active),
    .irq_mask_bit(irq_mask),
    .all_trap_mask_bit(all_mask)
  );

  // Control register writes
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= CTRL_RESET;
    end else if (mask_pulse) begin
      ctrl_reg[CTRL_PRESENT] <= avs_writedata[CTRL_PRESENT];
      ctrl_reg[CTRL_SUPER] <= avs_writedata[CTRL_SUPER];
    end
  end

  // Operand registers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      opa_reg <= 32'h0000_0000;
      opb_reg <= 32'h0000_0000;
    end else if (wr_acc && avs_address == OPA_OFS) begin
      opa_reg <= avs_writedata;
    end else if (wr_acc && avs_address == OPB_OFS) begin
      opb_reg <= avs_writedata;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= S_IDLE;
    end else begin
      unique case (state_reg)
        S_IDLE: begin
          if (go_store) begin
            state_reg <= S_STORE;
          end else if (go_load) begin
            state_reg <= S_LOAD;
          end
        end
        S_STORE, S_LOAD: begin
          if (done) begin
            state_reg <= S_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      result_reg <= 32'h0000_0000;
    end else if (done && state_reg == S_LOAD) begin
      result_reg <= chan_data_in;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      trap_reg <= TRAP_NONE;
    end else if (start && !ctrl_reg[CTRL_PRESENT]) begin
      trap_reg <= TRAP_NOTPRES;
    end else if (err_seen) begin
      trap_reg <= TRAP_CPEXC;
    end else if (trap_pulse) begin
      trap_reg <= TRAP_NONE;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      chan_req <= 1'b0;
      chan_rw <= 1'b0;
      coproc_select_line <= 1'b0;
      transfer_qualifier_line <= 1'b0;
      transfer_type_lines <= 3'h0;
      chan_addr <= 32'h0000_0000;
      chan_data_out <= 32'h0000_0000;
      chan_data_oe <= 1'b0;
    end else if (go_store || go_load) begin
      chan_req <= 1'b1;
      chan_rw <= go_load;
      coproc_select_line <= 1'b1;
      transfer_qualifier_line <= avs_writedata[CMD_TC];
      transfer_type_lines <= avs_writedata[CMD_OPT_LO +: 3];
      chan_addr <= go_load ? opb_reg : opa_reg;
      chan_data_out <= opb_reg;
      chan_data_oe <= go_store;
    end else if (done) begin
      chan_req <= 1'b0;
      coproc_select_line <= 1'b0;
      chan_data_oe <= 1'b0;
    end
  end

  // Status outputs
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      operation_active_out <= 1'b0;
      trap_pending <= 1'b0;
    end else begin
      operation_active_out <= active_flag;
      trap_pending <= trap_reg != TRAP_NONE;
    end
  end

  // Avalon answer: one wait cycle, then data
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_reg <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= UNMAPPED;
    end else begin
      ack_reg <= (avs_read || avs_write) && !ack_reg;
      avs_waitrequest <= !((avs_read || avs_write) && !ack_reg);
      if (rd_acc) begin
        unique case (avs_address)
          CTRL_OFS: avs_readdata <= {28'h0, all_mask, irq_mask, ctrl_reg[CTRL_SUPER], ctrl_reg[CTRL_PRESENT]};
          STAT_OFS: avs_readdata <= {28'h0, trap_reg == TRAP_CPEXC, trap_reg == TRAP_NOTPRES,
                                     state_reg != S_IDLE, active_flag};
          OPA_OFS: avs_readdata <= opa_reg;
          OPB_OFS: avs_readdata <= opb_reg;
          RES_OFS: avs_readdata <= result_reg;
          OLD_OFS: avs_readdata <= {31'h0, old_active};
          TRAP_OFS: avs_readdata <= {30'h0, trap_reg};
          default: avs_readdata <= UNMAPPED;
        endcase
      end
    end
  end

  property p_hold;
    @(posedge sys_clk) disable iff (!reset_n)
      (chan_req && !done) |=> $stable(chan_addr) && $stable(chan_rw) && $stable(transfer_type_lines);
  endproperty
  a_hold: assert property (p_hold)
    else $error("request changed before ack");
  property p_wait;
    @(posedge sys_clk) disable iff (!reset_n)
      (state_reg == S_STORE && !coproc_accept_line) |=> state_reg == S_STORE;
  endproperty
  a_wait: assert property (p_wait)
    else $error("store left without accept");
  property p_sel;
    @(posedge sys_clk) disable iff (!reset_n)
      chan_req |-> coproc_select_line;
  endproperty
  a_sel: assert property (p_sel)
    else $error("select low during request");
  property p_absent;
    @(posedge sys_clk) disable iff (!reset_n)
      (start && !ctrl_reg[CTRL_PRESENT]) |=> !chan_req && trap_reg == TRAP_NOTPRES;
  endproperty
  a_absent: assert property (p_absent)
    else $error("transfer without present bit");
  property p_err;
    @(posedge sys_clk) disable iff (!reset_n)
      err_seen |=> trap_reg == TRAP_CPEXC;
  endproperty
  a_err: assert property (p_err)
    else $error("error not trapped");
  property p_qual;
    @(posedge sys_clk) disable iff (!reset_n)
      chan_req |-> transfer_qualifier_line == hold[CMD_TC];
  endproperty
  a_qual: assert property (p_qual)
    else $error("qualifier differs from control bit");
  property p_dir;
    @(posedge sys_clk) disable iff (!reset_n)
      chan_req |-> chan_rw == hold[CMD_LOAD] && chan_data_oe == !hold[CMD_LOAD];
  endproperty
  a_dir: assert property (p_dir)
    else $error("direction differs from command");
  property p_operands;
    @(posedge sys_clk) disable iff (!reset_n)
      chan_req |-> chan_data_out == hold[OPB_MSB -: 32] &&
        chan_addr == (chan_rw ? hold[OPB_MSB -: 32] : hold[OPA_MSB -: 32]);
  endproperty
  a_operands: assert property (p_operands)
    else $error("operand buses differ from latched request");
  property p_store_done;
    @(posedge sys_clk) disable iff (!reset_n)
      state_reg == S_STORE |=> chan_req == !$past(coproc_accept_line);
  endproperty
  a_store_done: assert property (p_store_done)
    else $error("store end not tied to accept");
  property p_load_done;
    @(posedge sys_clk) disable iff (!reset_n)
      state_reg == S_LOAD |=> chan_req == !$past(data_ready_input);
  endproperty
  a_load_done: assert property (p_load_done)
    else $error("load end not tied to data ready");
  property p_result;
    @(posedge sys_clk) disable iff (!reset_n)
      (state_reg == S_LOAD && data_ready_input) |=> result_reg == $past(chan_data_in);
  endproperty
  a_result: assert property (p_result)
    else $error("result not taken from data bus");
  // Avalon one wait state
  property p_ack;
    @(posedge sys_clk) disable iff (!reset_n)
      ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest;
  endproperty
  a_ack: assert property (p_ack)
    else $error("bus request not answered");
  c_store: cover property (@(posedge sys_clk) state_reg == S_STORE ##1 state_reg == S_IDLE);
  c_load: cover property (@(posedge sys_clk) state_reg == S_LOAD ##1 state_reg == S_IDLE);
  c_err: cover property (@(posedge sys_clk) err_seen);
  c_notpres: cover property (@(posedge sys_clk) start && !ctrl_reg[CTRL_PRESENT]);
endmodule

// ### verif/coproc_model.sv
// Behavioural coprocessor on the far side of the channel.
// Assumes requests sampled on the rising edge of sys_clk.
`timescale 1ns/100ps
module coproc_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Channel request
  input wire logic chan_req,
  input wire logic chan_rw,
  input wire logic coproc_select_line,
  input wire logic transfer_qualifier_line,
  input wire logic [31:0] chan_addr,
  input wire logic [31:0] chan_data_out,
  // Answers
  output logic [31:0] chan_data_in,
  output logic coproc_accept_line,
  output logic data_ready_input,
  output logic data_error_input,
  // Bench controls
  input wire logic [3:0] op_cycles,
  input wire logic [1:0] ld_delay,
  input wire logic stall,
  input wire logic err_on
);
  logic [3:0] busy_reg;
  logic [1:0] wait_reg;
  logic [31:0] res_reg;
  logic take_st;
  logic take_ld;
  assign take_st = chan_req && coproc_select_line && !chan_rw && coproc_accept_line;
  assign take_ld = chan_req && coproc_select_line && chan_rw && !data_ready_input && wait_reg == ld_delay;
  assign coproc_accept_line = busy_reg == 4'h0 && !stall;
  assign data_error_input = err_on && chan_req && (chan_rw ? data_ready_input : coproc_accept_line);
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_reg <= 4'h0;
      wait_reg <= 2'h0;
      res_reg <= 32'h0;
      data_ready_input <= 1'b0;
      chan_data_in <= 32'h0;
    end else begin
      if (take_st && transfer_qualifier_line) begin
        busy_reg <= op_cycles;
        res_reg <= chan_addr + chan_data_out;
      end else if (busy_reg != 4'h0) begin
        busy_reg <= busy_reg - 4'h1;
      end
      data_ready_input <= take_ld;
      wait_reg <= (chan_req && chan_rw && !take_ld && !data_ready_input) ? wait_reg + 2'h1 : 2'h0;
      // Released data lines toggle
      chan_data_in <= take_ld ? res_reg : ~chan_data_in;
    end
  end
endmodule

// ### verif/coproc_channel_port_tb_top.sv
// Self-checking bench for the coprocessor channel port.
// Assumes the coprocessor model on the channel side.
`timescale 1ns/100ps
module coproc_channel_port_tb_top;
  import coproc_pkg::*;
  logic sys_clk, reset_n, avs_read, avs_write, avs_waitrequest, stall, err_on, act, tc, sa;
  logic [ADDR_W-1:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, chan_addr, chan_data_out, chan_data_in, opa, opb, res, cmd;
  logic chan_req, chan_rw, coproc_select_line, transfer_qualifier_line, chan_data_oe;
  logic coproc_accept_line, data_ready_input, data_error_input, operation_active_out, trap_pending;
  logic [2:0] transfer_type_lines, opt;
  logic [3:0] op_cycles;
  logic [1:0] ld_delay;
  logic [70:0] obs;
  typedef struct {logic [31:0] exp; logic [31:0] mask;} note_s;
  note_s rd_q[$];
  note_s n;
  logic [70:0] ch_q[$];
  int fails, compares, seed_dummy, i;
  coproc_channel_port DUT (.sys_clk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .chan_req, .chan_rw, .coproc_select_line, .transfer_qualifier_line,
    .transfer_type_lines, .chan_addr, .chan_data_out, .chan_data_oe, .chan_data_in, .coproc_accept_line,
    .data_ready_input, .data_error_input, .operation_active_out, .trap_pending);
  coproc_model partner (.sys_clk, .reset_n, .chan_req, .chan_rw, .coproc_select_line, .transfer_qualifier_line,
    .chan_addr, .chan_data_out, .chan_data_in, .coproc_accept_line, .data_ready_input, .data_error_input,
    .op_cycles, .ld_delay, .stall, .err_on);
  task automatic check(string nm, logic [70:0] e, logic [70:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic report_and_stop();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic bus(logic is_wr, logic [ADDR_W-1:0] a, logic [31:0] d, logic [31:0] e, logic [31:0] m,
    output logic [31:0] q);
    int t;
    if (!is_wr) rd_q.push_back('{e, m});
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= is_wr;
    avs_read <= !is_wr;
    t = 0;
    do begin
      @(posedge sys_clk);
      t++;
    end while (avs_waitrequest !== 1'b0 && t < 50);
    q = avs_readdata;
    if (t >= 50) check("waitrequest", 71'h0, 71'h1);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wr(logic [ADDR_W-1:0] a, logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 32'h0, 32'h0, q);
  endtask
  task automatic rd(logic [ADDR_W-1:0] a, logic [31:0] e, logic [31:0] m);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, e, m, q);
  endtask
  task automatic idle();
    logic [31:0] q;
    int t;
    t = 0;
    do begin
      bus(1'b0, STAT_OFS, 32'h0, 32'h0, 32'h0, q);
      t++;
    end while (q[ST_BUSY] !== 1'b0 && t < 100);
    if (t >= 100) check("busy", 71'h0, 71'h1);
  endtask
  // Oldest note against each answer
  always @(posedge sys_clk) begin
    if (avs_read && avs_waitrequest === 1'b0 && rd_q.size() > 0) begin
      n = rd_q.pop_front();
      if (n.mask != 32'h0) check("readdata", 71'(n.exp & n.mask), 71'(avs_readdata & n.mask));
    end
    obs = {coproc_select_line, chan_rw, chan_data_oe, transfer_qualifier_line, transfer_type_lines, chan_addr,
      chan_rw ? 32'h0 : chan_data_out};
    if (chan_req === 1'b1 && (chan_rw ? data_ready_input : coproc_accept_line) === 1'b1) begin
      if (ch_q.size() == 0) check("unexpected transfer", 71'h0, 71'h1);
      else check("channel", ch_q.pop_front(), obs);
    end
  end
  always @(posedge sys_clk) stall <= ($urandom_range(0, 3) == 0);
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (40000) @(posedge sys_clk);
    fails++;
    report_and_stop();
  end
  initial begin
    reset_n = 1'b0;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    op_cycles = 4'h0;
    ld_delay = 2'h0;
    err_on = 1'b0;
    seed_dummy = $urandom(32'h8D9051F2);
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    rd(CTRL_OFS, {28'h0, CTRL_RESET}, 32'hFFFFFFFF);
    rd(STAT_OFS, 32'h0, 32'hF);
    wr(4'hC, 32'hFFFFFFFF);
    rd(4'hC, UNMAPPED, 32'hFFFFFFFF);
    $display("test reset done");
    wr(CTRL_OFS, 32'hF);
    rd(CTRL_OFS, 32'hF, 32'hF);
    wr(CTRL_OFS, 32'h1);
    wr(CTRL_OFS, 32'hD);
    rd(CTRL_OFS, 32'h1, 32'hF);
    $display("test masks done");
    wr(CTRL_OFS, 32'h0);
    wr(CMD_OFS, 32'h104);
    rd(TRAP_OFS, {30'h0, TRAP_NOTPRES}, 32'hFF);
    wr(CMD_OFS, 32'h200);
    wr(CTRL_OFS, 32'h1);
    $display("test not present done");
    act = 1'b0;
    res = 32'h0;
    for (i = 0; i < 16; i++) begin
      opa = $urandom;
      opb = $urandom;
      op_cycles <= 4'($urandom_range(0, 9));
      ld_delay <= 2'($urandom);
      tc = i[0];
      sa = i[1];
      opt = 3'(i >> 1);
      cmd = {23'h0, 1'b1, 1'b0, opt, 1'b0, sa, tc, 1'b0};
      wr(OPA_OFS, opa);
      wr(OPB_OFS, opb);
      ch_q.push_back({3'b101, tc, opt, opa, opb});
      wr(CMD_OFS, cmd);
      idle();
      if (tc) res = opa + opb;
      if (sa) act = 1'b1;
      rd(STAT_OFS, {31'h0, act}, 32'h1);
      check("active out", 71'(act), 71'(operation_active_out));
      ch_q.push_back({3'b110, !tc, opt, opb, 32'h0});
      wr(CMD_OFS, cmd ^ 32'h3);
      idle();
      if (sa) act = 1'b0;
      rd(STAT_OFS, {31'h0, act}, 32'h1);
      check("active out", 71'(act), 71'(operation_active_out));
      rd(RES_OFS, res, 32'hFFFFFFFF);
    end
    $display("test transfers done");
    err_on <= 1'b1;
    ch_q.push_back({3'b101, 1'b0, 3'h0, opa, opb});
    wr(CMD_OFS, 32'h104);
    idle();
    rd(TRAP_OFS, {30'h0, TRAP_CPEXC}, 32'hFF);
    check("trap pending", 71'h1, 71'(trap_pending));
    wr(CMD_OFS, 32'h200);
    ch_q.push_back({3'b110, 1'b1, 3'h0, opb, 32'h0});
    wr(CMD_OFS, 32'h103);
    idle();
    err_on <= 1'b0;
    rd(TRAP_OFS, {30'h0, TRAP_CPEXC}, 32'hFF);
    wr(CMD_OFS, 32'h200);
    rd(OLD_OFS, 32'h1, 32'h1);
    rd(TRAP_OFS, 32'h0, 32'hFF);
    check("trap pending", 71'h0, 71'(trap_pending));
    $display("test error trap done");
    if (ch_q.size() != 0) check("pending transfers", 71'h0, 71'(ch_q.size()));
    report_and_stop();
  end
endmodule
